// [verilog/plsc_pkg.sv]
package plsc_pkg;
  localparam int HINT_W       = 5;
  localparam int REG_W        = 5;
  localparam int ADDR_W       = 40;
  localparam int BLK_LSB      = 6;
  localparam int WAY_W        = 1;
  localparam int UC_CNT_W     = 4;

  localparam logic [4:0] HINT_LOAD       = 5'h00;
  localparam logic [4:0] HINT_STORE      = 5'h01;
  localparam logic [4:0] HINT_LOAD_STRM  = 5'h04;
  localparam logic [4:0] HINT_STORE_STRM = 5'h05;
  localparam logic [4:0] HINT_LOAD_RET   = 5'h06;
  localparam logic [4:0] HINT_STORE_RET  = 5'h07;

  localparam logic [0:0] WAY_ZERO        = 1'h0;
  localparam logic [0:0] WAY_ONE         = 1'h1;

  localparam int         UCW_WINDOW      = 3;
  localparam int         SETTLE_W        = 4;
  localparam int         SETTLE_CYC      = 8;
  localparam logic [1:0] UCW_HIST_ZERO   = 2'h0;
  localparam logic [63:0] CS_SUCCESS     = 64'h1;
  localparam logic [63:0] CS_FAIL        = 64'h0;
endpackage

// [verilog/plsc_ctrl.sv]
`timescale 1ns/1ps
// Contract
// - Prefetch requests fill into both secondary and primary data caches.
// - Five-bit hint decodes the action; hints 2-3 and 8-31 do nothing.
// - Hints 0 and 1 fill the least recently used way.
// - Hints 4 and 5 fill way 0.
// - Hints 6 and 7 fill way 1.
// - Store-intent hints request the block in exclusive state.
// - Linked load reads memory, records address and arms the link.
// - Exception, return, load, store, barrier, cache op or prefetch clears link.
// - External intervention-exclusive or invalidate on linked block clears link.
// - Intact link: conditional store writes memory then writes 1 to register.
// - Broken link: conditional store leaves memory and writes 0.
// - Result register is the same field that supplied the store data.
// - Linked loads and conditional stores imply no barrier ordering.
// - After barrier decode, fetch continues; later memory ops may issue.
// - Barrier graduates only after every older instruction completed.
// - Barrier waits while uncached buffer holds ordinary uncached stores.
// - Barrier waits if uncached write address issued in prior three link clocks.
// - Barrier graduates only while global performed input is asserted.
// - Uncached accelerated stores never block barrier graduation.
// - Instruction cache misses do not clear the link.
module plsc_ctrl (
  input  wire logic                           clock,
  input  wire logic                           resetn,
  input  wire logic                           clock_en,
  input  wire logic                           system_interface_clock,
  input  wire logic                           sys_rstn,
  input  wire logic                           prefetch_instr,
  input  wire logic [plsc_pkg::HINT_W-1:0]    prefetch_instr_hint,
  input  wire logic [plsc_pkg::ADDR_W-1:0]    mem_addr,
  input  wire logic [plsc_pkg::WAY_W-1:0]     least_recent_way,
  output logic                                prefetch_instr_req,
  output logic [plsc_pkg::ADDR_W-1:0]         prefetch_instr_addr,
  output logic [plsc_pkg::WAY_W-1:0]          prefetch_instr_way,
  output logic                                prefetch_instr_exclusive,
  output logic                                prefetch_instr_fill_primary,
  input  wire logic                           linked_load,
  input  wire logic                           linked_load_double,
  output logic                                ll_read_req,
  output logic                                link_armed,
  output logic [plsc_pkg::ADDR_W-1:0]         link_addr,
  input  wire logic                           conditional_store,
  input  wire logic                           conditional_store_double,
  input  wire logic [plsc_pkg::REG_W-1:0]     data_reg_field,
  input  wire logic [63:0]                    store_data,
  output logic                                cs_mem_write,
  output logic [plsc_pkg::ADDR_W-1:0]         cs_mem_addr,
  output logic [63:0]                         cs_mem_data,
  output logic                                cs_mem_double,
  output logic                                cs_reg_write,
  output logic [plsc_pkg::REG_W-1:0]          cs_reg_dest,
  output logic [63:0]                         cs_reg_value,
  input  wire logic                           exception_evt,
  input  wire logic                           exception_return,
  input  wire logic                           load_evt,
  input  wire logic                           store_evt,
  input  wire logic                           cache_op_evt,
  input  wire logic                           icache_miss,
  input  wire logic                           ext_interv_excl,
  input  wire logic                           ext_invalidate,
  input  wire logic [plsc_pkg::ADDR_W-1:0]    ext_addr,
  input  wire logic                           barrier_decode,
  input  wire logic                           older_all_done,
  input  wire logic                           uc_store_push,
  input  wire logic                           uc_store_pop,
  input  wire logic                           uc_accel_pending,
  input  wire logic                           uc_write_addr_cycle,
  input  wire logic                           global_performed_n,
  output logic                                barrier_pending,
  output logic                                barrier_graduate,
  output logic                                fetch_stall
);
  import plsc_pkg::*;

  // Link-clock side: history of uncached write address cycles
  logic       gp_s1;
  logic       gp_s2;
  logic       aw_s1;
  logic       aw_s2;
  logic [1:0] ucw_hist;
  logic       ucw_recent;
  always_ff @(posedge system_interface_clock) begin
    if (!sys_rstn) begin
      aw_s1      <= 1'b0;
      aw_s2      <= 1'b0;
      ucw_hist   <= UCW_HIST_ZERO;
      ucw_recent <= 1'b0;
    end else begin
      aw_s1      <= uc_write_addr_cycle;
      aw_s2      <= aw_s1;
      ucw_hist   <= {ucw_hist[0], aw_s2};
      ucw_recent <= aw_s2 | (|ucw_hist);
    end
  end

  // Performed flag into the link domain
  always_ff @(posedge system_interface_clock) begin
    if (!sys_rstn) begin
      gp_s1 <= 1'b1;
      gp_s2 <= 1'b1;
    end else begin
      gp_s1 <= global_performed_n;
      gp_s2 <= gp_s1;
    end
  end

  // Crossing into pipeline clock
  logic rc_s1;
  logic rc_s2;
  logic gpn_c1;
  logic gpn_c2;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rc_s1 <= 1'b1;
      rc_s2 <= 1'b1;
    end else if (clock_en) begin
      rc_s1 <= ucw_recent;
      rc_s2 <= rc_s1;
    end
  end

  // Performed flag into the pipeline domain
  always_ff @(posedge clock) begin
    if (!resetn) begin
      gpn_c1 <= 1'b1;
      gpn_c2 <= 1'b1;
    end else if (clock_en) begin
      gpn_c1 <= gp_s2;
      gpn_c2 <= gpn_c1;
    end
  end

  // Prefetch hint decode
  logic                 hint_valid;
  logic                 hint_store;
  logic [WAY_W-1:0]     hint_way;
  always_comb begin
    hint_valid = 1'b1;
    hint_store = 1'b0;
    hint_way   = least_recent_way;
    unique case (prefetch_instr_hint)
      HINT_LOAD:       hint_way = least_recent_way;
      HINT_STORE: begin
        hint_way   = least_recent_way;
        hint_store = 1'b1;
      end
      HINT_LOAD_STRM:  hint_way = WAY_ZERO;
      HINT_STORE_STRM: begin
        hint_way   = WAY_ZERO;
        hint_store = 1'b1;
      end
      HINT_LOAD_RET:   hint_way = WAY_ONE;
      HINT_STORE_RET: begin
        hint_way   = WAY_ONE;
        hint_store = 1'b1;
      end
      default:         hint_valid = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prefetch_instr_req          <= 1'b0;
      prefetch_instr_exclusive    <= 1'b0;
      prefetch_instr_fill_primary <= 1'b0;
    end else if (clock_en) begin
      prefetch_instr_req          <= prefetch_instr & hint_valid;
      prefetch_instr_fill_primary <= prefetch_instr & hint_valid;
      prefetch_instr_exclusive    <= prefetch_instr & hint_valid & hint_store;
    end
  end

  // Prefetch address and way, held between requests
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prefetch_instr_addr <= '0;
      prefetch_instr_way  <= '0;
    end else if (clock_en) begin
      if (prefetch_instr & hint_valid) begin
        prefetch_instr_addr <= mem_addr;
        prefetch_instr_way  <= hint_way;
      end
    end
  end

  // Link tracker
  logic ll_any;
  logic cs_any;
  logic local_kill;
  logic ext_kill;
  assign ll_any     = linked_load | linked_load_double;
  assign cs_any     = conditional_store | conditional_store_double;
  // Instruction cache misses are deliberately absent here
  assign local_kill = exception_evt | exception_return | load_evt | store_evt | barrier_decode
                    | cache_op_evt | prefetch_instr;
  assign ext_kill   = (ext_interv_excl | ext_invalidate)
                    & (ext_addr[ADDR_W-1:BLK_LSB] == link_addr[ADDR_W-1:BLK_LSB]);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      link_addr <= '0;
    end else if (clock_en) begin
      if (ll_any) begin
        link_addr <= mem_addr;
      end
    end
  end

  // Link flag; a kill in the linked load's own cycle loses
  always_ff @(posedge clock) begin
    if (!resetn) begin
      link_armed  <= 1'b0;
      ll_read_req <= 1'b0;
    end else if (clock_en) begin
      ll_read_req <= ll_any;
      if (ll_any) begin
        link_armed <= 1'b1;
      end else if (local_kill | ext_kill | cs_any) begin
        link_armed <= 1'b0;
      end
    end
  end

  logic cs_ok;
  assign cs_ok = cs_any & link_armed & ~local_kill & ~ext_kill;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cs_mem_write <= 1'b0;
    end else if (clock_en) begin
      cs_mem_write <= cs_ok;
    end
  end

  // Store payload, captured only on success
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cs_mem_addr   <= '0;
      cs_mem_data   <= '0;
      cs_mem_double <= 1'b0;
    end else if (clock_en) begin
      if (cs_ok) begin
        cs_mem_addr   <= mem_addr;
        cs_mem_data   <= store_data;
        cs_mem_double <= conditional_store_double;
      end
    end
  end

  // Register result one cycle after the memory write
  logic                 cs_pend;
  logic                 cs_pend_ok;
  logic [REG_W-1:0]     cs_pend_reg;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cs_pend      <= 1'b0;
      cs_pend_ok   <= 1'b0;
      cs_pend_reg  <= '0;
      cs_reg_write <= 1'b0;
    end else if (clock_en) begin
      cs_pend      <= cs_any;
      cs_pend_ok   <= cs_ok;
      cs_pend_reg  <= data_reg_field;
      cs_reg_write <= cs_pend;
    end
  end

  // Result register field and flag value
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cs_reg_dest  <= '0;
      cs_reg_value <= CS_FAIL;
    end else if (clock_en) begin
      if (cs_pend) begin
        cs_reg_dest  <= cs_pend_reg;
        cs_reg_value <= cs_pend_ok ? CS_SUCCESS : CS_FAIL;
      end
    end
  end

  // Barrier graduation gate
  logic [UC_CNT_W-1:0] uc_count;
  logic                uc_push_ok;
  logic                uc_pop_ok;
  assign uc_push_ok = uc_store_push & ~(&uc_count);
  assign uc_pop_ok  = uc_store_pop & (|uc_count);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      uc_count <= '0;
    end else if (clock_en) begin
      if (uc_push_ok & ~uc_pop_ok) begin
        uc_count <= uc_count + 1'b1;
      end else if (uc_pop_ok & ~uc_push_ok) begin
        uc_count <= uc_count - 1'b1;
      end
    end
  end

  // Settle wait so link-side events before decode reach the gate
  logic [SETTLE_W-1:0] settle_cnt;
  logic                settled;
  assign settled = (settle_cnt == SETTLE_W'(SETTLE_CYC));
  always_ff @(posedge clock) begin
    if (!resetn) begin
      settle_cnt <= '0;
    end else if (clock_en) begin
      if (!barrier_pending | barrier_decode) begin
        settle_cnt <= '0;
      end else if (!settled) begin
        settle_cnt <= settle_cnt + 1'b1;
      end
    end
  end

  logic grad_ok;
  // Accelerated stores are tracked apart and never gate graduation
  assign grad_ok = older_all_done
                 & (uc_count == '0)
                 & ~rc_s2
                 & settled
                 & ~gpn_c2;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      barrier_pending  <= 1'b0;
      barrier_graduate <= 1'b0;
    end else if (clock_en) begin
      barrier_graduate <= barrier_pending & grad_ok;
      if (barrier_pending & grad_ok) begin
        barrier_pending <= barrier_decode;
      end else if (barrier_decode) begin
        barrier_pending <= 1'b1;
      end
    end
  end

  // Fetch never stalls behind a barrier
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fetch_stall <= 1'b0;
    end else if (clock_en) begin
      fetch_stall <= 1'b0;
    end
  end

  // Linked ops never enter the barrier gate
  logic unused_ok;
  assign unused_ok = uc_accel_pending & icache_miss;
endmodule

// [verif/plsc_ctrl_asserts.sv]
`timescale 1ns/1ps
module plsc_ctrl_asserts (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        clock_en,
  input wire logic        prefetch_instr,
  input wire logic [4:0]  prefetch_instr_hint,
  input wire logic [0:0]  least_recent_way,
  input wire logic        prefetch_instr_req,
  input wire logic [0:0]  prefetch_instr_way,
  input wire logic        prefetch_instr_exclusive,
  input wire logic        linked_load,
  input wire logic        linked_load_double,
  input wire logic        ll_read_req,
  input wire logic        link_armed,
  input wire logic        conditional_store,
  input wire logic        conditional_store_double,
  input wire logic [4:0]  data_reg_field,
  input wire logic        cs_mem_write,
  input wire logic        cs_reg_write,
  input wire logic [4:0]  cs_reg_dest,
  input wire logic [63:0] cs_reg_value,
  input wire logic        exception_evt,
  input wire logic        exception_return,
  input wire logic        load_evt,
  input wire logic        store_evt,
  input wire logic        cache_op_evt,
  input wire logic        barrier_decode,
  input wire logic        older_all_done,
  input wire logic        global_performed_n,
  input wire logic        barrier_pending,
  input wire logic        barrier_graduate
);
  import plsc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire pv = prefetch_instr && clock_en;
  wire hs = prefetch_instr_hint[0];
  wire cs = (conditional_store || conditional_store_double) && clock_en;
  wire kill = exception_evt || exception_return || load_evt || store_evt || cache_op_evt || barrier_decode || pv;
  logic [3:0] gpn_high_run;
  always_ff @(posedge clock) begin
    if (!resetn) gpn_high_run <= 4'h0;
    else if (!global_performed_n) gpn_high_run <= 4'h0;
    else if (gpn_high_run != 4'hf) gpn_high_run <= gpn_high_run + 4'h1;
  end

  a_hint_undef: assert property (pv && (prefetch_instr_hint[4:1] == 4'h1 || prefetch_instr_hint >= 5'h08) |=> !prefetch_instr_req)
    else $error("undefined hint made a request");
  a_hint_lru: assert property (pv && prefetch_instr_hint[4:1] == 4'h0 |=> prefetch_instr_req && prefetch_instr_way == $past(least_recent_way))
    else $error("hint 0 or 1 missed the least recent way");
  a_hint_way0: assert property (pv && prefetch_instr_hint[4:1] == 4'h2 |=> prefetch_instr_req && prefetch_instr_way == WAY_ZERO)
    else $error("streamed hint missed way 0");
  a_hint_way1: assert property (pv && prefetch_instr_hint[4:1] == 4'h3 |=> prefetch_instr_req && prefetch_instr_way == WAY_ONE)
    else $error("retained hint missed way 1");
  a_hint_excl: assert property (prefetch_instr_req |-> prefetch_instr_exclusive == $past(hs))
    else $error("exclusive request wrong");
  a_link_arm: assert property (linked_load && clock_en |=> link_armed && ll_read_req)
    else $error("linked load did not arm");
  a_link_kill: assert property (kill && clock_en && !linked_load && !linked_load_double |=> !link_armed)
    else $error("link survived a kill");
  a_cs_fail: assert property (cs && !link_armed |=> !cs_mem_write ##1 cs_reg_write && cs_reg_value == CS_FAIL)
    else $error("unlinked store did not fail");
  a_cs_dest: assert property (cs |=> ##1 cs_reg_write && cs_reg_dest == $past(data_reg_field, 2))
    else $error("result register differs from data field");
  a_grad_order: assert property (barrier_graduate |-> $past(barrier_pending) && $past(older_all_done))
    else $error("barrier graduated too early");
  a_grad_perf: assert property (barrier_graduate |-> gpn_high_run < 4'h8)
    else $error("barrier graduated without performed");
endmodule

bind plsc_ctrl plsc_ctrl_asserts u_chk (.*);

// [verif/plsc_agent.sv]
`timescale 1ns/1ps
module plsc_agent (
  input  wire logic       sys_clk,
  input  wire logic       sys_rstn,
  input  wire logic       wr_issue,
  input  wire logic [4:0] wr_lat,
  output logic            addr_cycle,
  output logic            gp_n
);
  logic       prev;
  logic [4:0] left;
  always_ff @(posedge sys_clk) begin
    prev <= wr_issue;
    addr_cycle <= sys_rstn && wr_issue && !prev;
    if (!sys_rstn) left <= 5'h00;
    else if (wr_issue && !prev) left <= wr_lat;
    else if (left != 5'h00) left <= left - 5'h01;
  end
  // Low only with no write outstanding
  assign gp_n = left != 5'h00;
endmodule

// [verif/tb_prefetch_linked_sync_control.sv]
`timescale 1ns/1ps
module tb_prefetch_linked_sync_control;
  import plsc_pkg::*;
  logic clock = 0, system_interface_clock = 0, resetn = 0, clock_en = 1, pf = 0, bd = 0, wr = 0;
  logic linked_load = 0, linked_load_double = 0, conditional_store = 0, conditional_store_double = 0;
  logic older_all_done = 1, uc_store_push = 0, uc_store_pop = 0, uc_accel_pending = 0;
  logic [4:0] prefetch_instr_hint = 0, data_reg_field = 0, lat = 0;
  logic [0:0] least_recent_way = 0, prefetch_instr_way;
  logic [39:0] mem_addr = 0, ext_addr = 0, prefetch_instr_addr, link_addr, cs_mem_addr;
  logic [63:0] store_data = 0, cs_mem_data, cs_reg_value;
  logic [9:0] ev = 0;
  logic [4:0] cs_reg_dest;
  logic prefetch_instr_req, prefetch_instr_exclusive, prefetch_instr_fill_primary, ll_read_req, link_armed, cs_mem_write, cs_mem_double;
  logic cs_reg_write, barrier_pending, barrier_graduate, fetch_stall;
  wire logic sys_rstn, prefetch_instr, barrier_decode, icache_miss, exception_evt, exception_return, load_evt;
  wire logic store_evt, cache_op_evt, ext_interv_excl, ext_invalidate, pp, pb, uc_write_addr_cycle, global_performed_n;
  int num_errors = 0, tests_run = 0;

  assign {ext_invalidate, ext_interv_excl, pb, pp, cache_op_evt, store_evt, load_evt} = ev[9:3];
  assign {exception_return, exception_evt, icache_miss} = ev[2:0];
  assign prefetch_instr = pf | pp;
  assign barrier_decode = bd | pb;
  assign sys_rstn = resetn;
  always #4 clock = ~clock;
  always #7.5 system_interface_clock = ~system_interface_clock;

  plsc_ctrl uut (.*);
  plsc_agent agent (.sys_clk(system_interface_clock), .sys_rstn(sys_rstn), .wr_issue(wr), .wr_lat(lat),
    .addr_cycle(uc_write_addr_cycle), .gp_n(global_performed_n));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic t_prefetch_instr;
    logic [4:0] h;
    logic       v;
    for (int i = 0; i <= 32; i++) begin
      @(negedge clock);
      if (i > 0) begin
        h = 5'(i - 1);
        v = h < 5'h08 && h[2:1] != 2'h1;
        chk("prefetch_instr_req", 64'(v), 64'(prefetch_instr_req));
        if (v) chk("prefetch_instr_way", 64'(h[2] ? h[1] : !h[0]), 64'(prefetch_instr_way));
        if (v) chk("prefetch_instr_excl", 64'(h[0]), 64'(prefetch_instr_exclusive));
        if (v) chk("prefetch_instr_addr", 64'(40'(h) << BLK_LSB), 64'(prefetch_instr_addr));
        if (v) chk("fill_primary", 64'h1, 64'(prefetch_instr_fill_primary));
      end
      pf = i < 32;
      prefetch_instr_hint = 5'(i);
      mem_addr = 40'(prefetch_instr_hint) << BLK_LSB;
      least_recent_way = !prefetch_instr_hint[0];
    end
    $display("test prefetch done");
  endtask

  task automatic t_link(input int k);
    logic ok;
    ok = k == 0 || k == 1 || k == 11;
    @(negedge clock);
    linked_load = k != 12 && k != 3;
    linked_load_double = k == 3;
    mem_addr = 40'h12_3456_7840;
    @(negedge clock);
    linked_load = 0;
    linked_load_double = 0;
    if (k != 12) chk("link_armed", 64'h1, 64'(link_armed & ll_read_req));
    if (k != 12) chk("link_addr", 64'(mem_addr), 64'(link_addr));
    ev = (k > 0 && k < 11) ? 10'(1 << (k - 1)) : (k == 11 ? 10'h100 : 10'h0);
    ext_addr = mem_addr + (k == 11 ? 40'h40 : 40'h8);
    @(negedge clock);
    ev = 0;
    conditional_store = k % 2 == 0;
    conditional_store_double = k % 2 == 1;
    data_reg_field = 5'(k + 3);
    store_data = 64'(k) + 64'h5a00;
    @(negedge clock);
    conditional_store = 0;
    conditional_store_double = 0;
    chk("cs_mem_write", 64'(ok), 64'(cs_mem_write));
    if (ok) chk("cs_mem_data", store_data, cs_mem_data);
    if (ok) chk("cs_mem_addr", 64'(mem_addr), 64'(cs_mem_addr));
    if (ok) chk("cs_mem_double", 64'(k % 2), 64'(cs_mem_double));
    @(negedge clock);
    chk("cs_reg_write", 64'h1, 64'(cs_reg_write));
    chk("cs_reg_dest", 64'(k + 3), 64'(cs_reg_dest));
    chk("cs_reg_value", ok ? CS_SUCCESS : CS_FAIL, cs_reg_value);
    $display("test link case %0d done", k);
  endtask

  task automatic t_freeze;
    @(negedge clock);
    clock_en = 0;
    linked_load = 1;
    pf = 1;
    prefetch_instr_hint = HINT_LOAD;
    repeat (2) @(negedge clock);
    chk("frozen_link", 64'h0, 64'(link_armed));
    chk("frozen_prefetch_instr", 64'h0, 64'(prefetch_instr_req));
    clock_en = 1;
    @(negedge clock);
    linked_load = 0;
    pf = 0;
    chk("thawed_link", 64'h1, 64'(link_armed));
    $display("test freeze done");
  endtask

  task automatic t_bar(input int m, input int hold);
    int n;
    n = 0;
    while ((barrier_pending || global_performed_n) && n < 300) begin
      @(negedge clock);
      n++;
    end
    older_all_done = m != 1;
    uc_store_push = m == 2;
    uc_accel_pending = m == 3;
    wr = m > 3;
    lat = m == 4 ? 5'h0f : 5'h00;
    @(negedge clock);
    uc_store_push = 0;
    n = 0;
    while (m > 3 && uc_write_addr_cycle !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    bd = 1;
    @(negedge clock);
    bd = 0;
    wr = 0;
    chk("fetch_stall", 64'h0, 64'(fetch_stall));
    n = 0;
    repeat (hold) begin
      @(negedge clock);
      if (barrier_graduate !== 1'b0) n++;
    end
    chk("early_graduate", 64'h0, 64'(n));
    older_all_done = 1;
    uc_store_pop = m == 2;
    @(negedge clock);
    uc_store_pop = 0;
    n = 0;
    while (barrier_graduate !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk("graduated", 64'h1, 64'(barrier_graduate));
    if (n >= 200) finish_test;
    $display("test barrier mode %0d done", m);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    resetn = 1;
    t_prefetch_instr;
    for (int k = 0; k <= 12; k++) t_link(k);
    t_freeze;
    t_bar(0, 0);
    t_bar(1, 20);
    t_bar(2, 20);
    t_bar(3, 0);
    t_bar(4, 20);
    t_bar(5, 5);
    finish_test;
  end
endmodule
